// ### sbw_core.sv
// subtract-from-working sequencer: decode, operand read, write back
// assumes the fetch unit holds instr stable for a whole cycle
// and data memory answers a read combinationally in the same clock
`timescale 1ns/1ps
`include "sbw_consts.svh"

// Behaviour
// (RULE1) opcode 0000 1000 kkkkkkkk computes literal minus working register.
// (RULE2) the literal form writes the working register and all five flags.
// (RULE3) opcode 0101 11da ffffffff computes file minus working register with the same flags.
// (RULE4) destination bit 0 writes the working register, 1 writes the file register.
// (RULE5) access bit 0 picks the access bank, 1 lets the bank select register choose the bank.
// (RULE6) access bit 0 with extended set on and address up to 95 uses indexed literal offset.
// (RULE7) the file form is one word and one cycle: decode, read, process, write by quarter.
// (RULE8) the literal form is one word and one cycle: decode, read literal, process, write.
// (RULE9) carry is inverted borrow and zero is set only for a zero result.
// (RULE10) negative copies result bit 7 and signed_wrap_flag marks signed overflow.
module sbw_core (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // instruction from fetch
    input wire logic [15:0] instr,
    input wire logic instr_valid,
    input wire logic ext_set_en,
    input wire logic [3:0] bank_select_register,
    // data memory
    output logic [7:0] mem_bank_r,
    output logic [7:0] mem_addr_r,
    output logic [1:0] mem_mode_r,
    output logic mem_rd_r,
    input wire logic [7:0] mem_rdata,
    output logic mem_wr_r,
    output logic [7:0] mem_wdata_r,
    // architectural state
    output logic [7:0] working_r,
    output logic [4:0] status_r,
    output logic [1:0] phase_r,
    output logic done_r
);
    import sbw_pkg::*;

    // ************************************************************
    // decode
    // ************************************************************
    sbw_phase_e ph_r;
    sbw_phase_e ph_nxt;
    sbw_op_e op_r;
    logic [15:0] ir_r;
    logic [7:0] opa_r;
    logic [7:0] res_r;
    logic [4:0] fl_r;

    function automatic sbw_op_e decode_op(input logic [15:0] w);
        if (w[15:8] == `SBW_LIT_OPC) begin
            decode_op = SBW_OP_LIT;   // [RULE1]
        end else if (w[15:10] == `SBW_FILE_OPC) begin
            decode_op = SBW_OP_FILE;   // [RULE3]
        end else begin
            decode_op = SBW_OP_NONE;
        end
    endfunction

    // one decode serves both the request edge and the q2 refresh
    function automatic sbw_bank_e bank_of(input logic acc, input logic ext, input logic [7:0] fa);
        if (acc) begin
            bank_of = SBW_BANK_BANKED;   // [RULE5]
        end else if (ext && fa <= `SBW_INDEX_MAX) begin
            bank_of = SBW_BANK_INDEXED;   // [RULE6]
        end else begin
            bank_of = SBW_BANK_ACCESS;   // [RULE5]
        end
    endfunction

    sbw_op_e dec_op_w;
    wire take_w;
    wire dst_file_w;
    wire acc_bit_w;
    wire [7:0] faddr_w;
    sbw_bank_e bank_w;
    sbw_bank_e req_bank_w;
    assign dec_op_w = decode_op(instr);
    // a word is ours only when q1 sees a recognised opcode
    assign take_w = (ph_r == SBW_Q1) && (ph_nxt == SBW_Q2);
    assign dst_file_w = ir_r[`SBW_D_BIT];
    assign acc_bit_w = ir_r[`SBW_A_BIT];
    assign faddr_w = ir_r[7:0];
    // indexed mode overrides access bank only in the low window
    assign bank_w = bank_of(acc_bit_w, ext_set_en, faddr_w);
    assign req_bank_w = bank_of(instr[`SBW_A_BIT], ext_set_en, instr[7:0]);

    // ************************************************************
    // subtractor
    // ************************************************************
    sbw_alu_if alu_io ();
    assign alu_io.minuend = opa_r;
    assign alu_io.subtrahend = working_r;
    sbw_sub u_sub (
        .io(alu_io)
    );

    // ************************************************************
    // quarter sequencer
    // ************************************************************
    // a cycle starts only on a recognised instruction; others are not ours
    always_comb begin
        case (ph_r)
            SBW_Q1: ph_nxt = (instr_valid && dec_op_w != SBW_OP_NONE) ? SBW_Q2 : SBW_Q1;
            SBW_Q2: ph_nxt = SBW_Q3;
            SBW_Q3: ph_nxt = SBW_Q4;
            SBW_Q4: ph_nxt = SBW_Q1;
            default: ph_nxt = SBW_Q1;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ph_r <= SBW_Q1;
        end else begin
            ph_r <= ph_nxt;   // [RULE7] [RULE8]
        end
    end

    // ************************************************************
    // q1 decode
    // ************************************************************
    // q1: latch the word
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ir_r <= 16'h0000;
            op_r <= SBW_OP_NONE;
        end else if (take_w) begin
            ir_r <= instr;
            op_r <= dec_op_w;
        end
    end

    // ************************************************************
    // q2 operand read
    // ************************************************************
    // q2: fetch the minuend, literal or file
    always_ff @(posedge clk) begin
        if (!nrst) begin
            opa_r <= 8'h00;
        end else if (ph_r == SBW_Q2) begin
            opa_r <= (op_r == SBW_OP_LIT) ? ir_r[7:0] : mem_rdata;   // [RULE8] [RULE7]
        end
    end

    // ************************************************************
    // data memory request
    // ************************************************************
    // address is issued in q1 so memory answers during q2
    // costs one register stage but keeps memory timing off the decode path
    always_ff @(posedge clk) begin
        if (!nrst) begin
            mem_rd_r <= 1'b0;
            mem_addr_r <= 8'h00;
            mem_bank_r <= 8'h00;
            mem_mode_r <= 2'h0;
        end else begin
            mem_rd_r <= take_w && (dec_op_w == SBW_OP_FILE);
            if (take_w) begin
                mem_addr_r <= instr[7:0];
                mem_bank_r <= {4'h0, bank_select_register};
                mem_mode_r <= req_bank_w;   // [RULE5] [RULE6]
            end else if (ph_r == SBW_Q2) begin
                mem_mode_r <= bank_w;
            end
        end
    end

    // ************************************************************
    // q3 process
    // ************************************************************
    // q3: process
    always_ff @(posedge clk) begin
        if (!nrst) begin
            res_r <= 8'h00;
            fl_r <= `SBW_ST_RST;
        end else if (ph_r == SBW_Q3) begin
            res_r <= alu_io.diff;   // [RULE1] [RULE3]
            fl_r <= alu_io.flags;   // [RULE9] [RULE10]
        end
    end

    // ************************************************************
    // q4 write back
    // ************************************************************
    // q4: write back; flags are updated by both forms
    wire wr_file_w;
    assign wr_file_w = (op_r == SBW_OP_FILE) && dst_file_w;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            working_r <= `SBW_W_RST;
            status_r <= `SBW_ST_RST;
            mem_wr_r <= 1'b0;
            mem_wdata_r <= 8'h00;
            done_r <= 1'b0;
        end else begin
            mem_wr_r <= 1'b0;
            done_r <= 1'b0;
            if (ph_r == SBW_Q4) begin
                status_r <= fl_r;   // [RULE2] [RULE3]
                done_r <= 1'b1;
                if (wr_file_w) begin
                    mem_wr_r <= 1'b1;   // [RULE4]
                    mem_wdata_r <= res_r;
                end else begin
                    working_r <= res_r;   // [RULE2] [RULE4]
                end
            end
        end
    end

    // ************************************************************
    // phase report
    // ************************************************************
    // mirrors the next phase so the port shows the quarter now running
    always_ff @(posedge clk) begin
        if (!nrst) begin
            phase_r <= 2'h0;
        end else begin
            phase_r <= ph_nxt;
        end
    end
endmodule

// ### sbw_consts.svh
// constants for the subtract-from-working datapath
// assumes inclusion by bare name from the core and subtractor modules
`ifndef SBW_CONSTS_SVH
`define SBW_CONSTS_SVH

// ************************************************************
// opcode fields
// ************************************************************
`define SBW_LIT_OPC 8'h08
`define SBW_FILE_OPC 6'h17
`define SBW_D_BIT 9
`define SBW_A_BIT 8
`define SBW_INDEX_MAX 8'h5F

// ************************************************************
// status bit positions
// ************************************************************
`define SBW_ST_C 0
`define SBW_ST_HALF 1
`define SBW_ST_Z 2
`define SBW_ST_WRAP 3
`define SBW_ST_N 4

// ************************************************************
// reset values
// ************************************************************
`define SBW_W_RST 8'h00
`define SBW_ST_RST 5'h00

`endif

// ### sbw_pkg.sv
// types for the subtract-from-working datapath
// assumes sbw_consts.svh is on the include path
package sbw_pkg;
    // quarter phases, gray coded along the cycle
    typedef enum logic [1:0] {
        SBW_Q1 = 2'b00,
        SBW_Q2 = 2'b01,
        SBW_Q3 = 2'b11,
        SBW_Q4 = 2'b10
    } sbw_phase_e;

    typedef enum logic [1:0] {
        SBW_OP_NONE = 2'b00,
        SBW_OP_LIT = 2'b01,
        SBW_OP_FILE = 2'b10
    } sbw_op_e;

    typedef enum logic [1:0] {
        SBW_BANK_ACCESS = 2'b00,
        SBW_BANK_BANKED = 2'b01,
        SBW_BANK_INDEXED = 2'b10
    } sbw_bank_e;
endpackage

// ### sbw_alu_if.sv
// operand and result bundle between the sequencer and the subtractor
// assumes both ends run on one clock
`timescale 1ns/1ps
interface sbw_alu_if;
    logic [7:0] minuend;
    logic [7:0] subtrahend;
    logic [7:0] diff;
    logic [4:0] flags;
    modport ctl (output minuend, output subtrahend, input diff, input flags);
    modport alu (input minuend, input subtrahend, output diff, output flags);
endinterface

// ### sbw_sub.sv
// combinational 8-bit subtractor with status flags
// assumes operands held stable by the sequencer
`timescale 1ns/1ps
`include "sbw_consts.svh"
module sbw_sub (
    sbw_alu_if.alu io
);
    import sbw_pkg::*;

    wire [8:0] full_w;
    wire [4:0] low_w;
    wire [7:0] res_w;
    // borrow-free difference keeps the extra bit as inverted borrow
    assign full_w = {1'b0, io.minuend} + {1'b0, ~io.subtrahend} + 9'h001;
    assign low_w = {1'b0, io.minuend[3:0]} + {1'b0, ~io.subtrahend[3:0]} + 5'h01;
    assign res_w = full_w[7:0];
    assign io.diff = res_w;
    assign io.flags[`SBW_ST_C] = full_w[8];   // [RULE9]
    assign io.flags[`SBW_ST_HALF] = low_w[4];
    assign io.flags[`SBW_ST_Z] = (res_w == 8'h00);   // [RULE9]
    // [RULE10]
    assign io.flags[`SBW_ST_WRAP] = (io.minuend[7] != io.subtrahend[7]) &&
                                  (res_w[7] != io.minuend[7]);
    assign io.flags[`SBW_ST_N] = res_w[7];   // [RULE10]
endmodule

// ### sbw_core_properties.sv
// port assertions for the subtract sequencer
// assumes one clock and a sync active-low reset
`timescale 1ns/1ps
module sbw_chk (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] mem_addr_r,
    input wire logic [1:0] mem_mode_r,
    input wire logic mem_rd_r,
    input wire logic mem_wr_r,
    input wire logic [7:0] mem_wdata_r,
    input wire logic [7:0] working_r,
    input wire logic [4:0] status_r,
    input wire logic [1:0] phase_r,
    input wire logic done_r
);
    wire [7:0] res = mem_wr_r ? mem_wdata_r : working_r;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_rd_one; mem_rd_r |=> !mem_rd_r; endproperty
    a_rd_one: assert property (p_rd_one) else $error("read strobe long");
    property p_rd_done; mem_rd_r |-> ##3 done_r; endproperty
    a_rd_done: assert property (p_rd_done) else $error("no done");
    property p_wr_done; mem_wr_r |-> done_r && phase_r == 2'b00; endproperty
    a_wr_done: assert property (p_wr_done) else $error("write off q4");
    property p_done_one; done_r |=> !done_r; endproperty
    a_done_one: assert property (p_done_one) else $error("done long");
    property p_zero; done_r |-> status_r[2] == (res == 8'h00); endproperty
    a_zero: assert property (p_zero) else $error("zero flag");
    property p_neg; done_r |-> status_r[4] == res[7]; endproperty
    a_neg: assert property (p_neg) else $error("negative flag");
    property p_idx; mem_rd_r && mem_mode_r == 2'h2 |-> mem_addr_r <= 8'h5F; endproperty
    a_idx: assert property (p_idx) else $error("indexed above 95");
    // guard skips the edge where reset just cleared w
    property p_w_hold; $changed(working_r) && $past(nrst) |-> done_r; endproperty
    a_w_hold: assert property (p_w_hold) else $error("w moved");
endmodule
bind sbw_core sbw_chk u_chk (.clk(clk), .nrst(nrst), .mem_addr_r(mem_addr_r),
    .mem_mode_r(mem_mode_r), .mem_rd_r(mem_rd_r), .mem_wr_r(mem_wr_r),
    .mem_wdata_r(mem_wdata_r), .working_r(working_r), .status_r(status_r),
    .phase_r(phase_r), .done_r(done_r));

// ### sbw_mem_model.sv
// data memory partner, read answered in the same cycle
// assumes one-cycle strobes; banks folded onto one array
`timescale 1ns/1ps
module sbw_mem_model (
    input wire logic clk,
    input wire logic rd,
    input wire logic wr,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    logic [7:0] mem [256];
    logic [7:0] last_r = 8'h00;
    // scrambled off-strobe so a late sample cannot pass
    assign rdata = rd ? mem[addr] : ~last_r;
    initial for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'hA5;
    always @(posedge clk) begin
        if (rd) last_r <= mem[addr];
        if (wr) mem[addr] <= wdata;
    end
endmodule

// ### subtract_w_instructions_tb.sv
// self-checking bench for the subtract sequencer
// assumes the design, checker and memory model compiled first
`timescale 1ns/1ps
module subtract_w_instructions_tb;
    logic clk = 0, nrst = 0, iv = 0, ext = 0;
    logic [15:0] instr = 16'h0000;
    logic [3:0] bank_sel = 4'h0;
    logic [7:0] m [256];
    logic [7:0] w = 8'h00, op, res;
    wire [7:0] bank, addr, rdata, wdata, working;
    wire [4:0] status;
    wire [1:0] mode;
    wire rd, wr, done;
    int fails = 0, checked = 0, seed = 92486, r;
    always #2 clk = ~clk;
    sbw_core dut (.clk(clk), .nrst(nrst), .instr(instr), .instr_valid(iv),
        .ext_set_en(ext), .bank_select_register(bank_sel), .mem_bank_r(bank),
        .mem_addr_r(addr), .mem_mode_r(mode), .mem_rd_r(rd), .mem_rdata(rdata),
        .mem_wr_r(wr), .mem_wdata_r(wdata), .working_r(working),
        .status_r(status), .phase_r(), .done_r(done));
    sbw_mem_model u_mem (.clk(clk), .rd(rd), .wr(wr), .addr(addr),
        .wdata(wdata), .rdata(rdata));
    function automatic logic [4:0] flags(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        s = {1'b0, a} - {1'b0, b};
        return {s[7], (a[7] ^ b[7]) & (a[7] ^ s[7]), s[7:0] == 8'h00,
            a[3:0] >= b[3:0], ~s[8]};
    endfunction
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        checked++;
        if (e !== s) begin
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
            fails++;
        end
    endtask
    task automatic give_verdict;
        if (fails == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // reset clears working and status; memory keeps its words
    task automatic reset_pulse(input int cycles);
        nrst <= 1'b0;
        repeat (cycles) @(posedge clk);
        nrst <= 1'b1;
        #1;
        w = 8'h00;
        chk("reset working", 8'h00, working);
        chk("reset status", 8'h00, 8'(status));
        chk("reset write", 8'h00, 8'(wr));
        chk("reset done", 8'h00, 8'(done));
    endtask
    task automatic run(input logic [15:0] wd, input logic [3:0] b, input logic x);
        logic lit, fil;
        int n;
        lit = wd[15:8] == 8'h08;
        fil = wd[15:10] == 6'h17;
        n = 0;
        @(posedge clk);
        instr <= wd;
        iv <= 1'b1;
        bank_sel <= b;
        ext <= x;
        @(posedge clk);
        iv <= 1'b0;
        #1;
        chk("read", 8'(fil), 8'(rd));
        if (fil) begin
            chk("addr", wd[7:0], addr);
            chk("bank", {4'h0, b}, bank);
            chk("mode", wd[8] ? 8'h01 : 8'(x && wd[7:0] <= 8'h5F) << 1, 8'(mode));
        end
        op = lit ? wd[7:0] : m[wd[7:0]];
        res = op - w;
        while (done !== 1'b1 && n < 8) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (lit || fil) begin
            chk("cycles", 8'h01, 8'(n == 3));
            chk("flags", 8'(flags(op, w)), 8'(status));
            chk("write", 8'(fil && wd[9]), 8'(wr));
            if (fil && wd[9]) begin
                chk("wdata", res, wdata);
                m[wd[7:0]] = res;
            end else w = res;
            chk("working", w, working);
        end else begin
            chk("ignored", 8'h00, 8'(done));
            chk("ignored working", w, working);
        end
    endtask
    initial begin
        for (int i = 0; i < 256; i++) m[i] = i[7:0] ^ 8'hA5;
        reset_pulse(5);
        run(16'h0802, 4'h0, 1'b0);
        run(16'h0802, 4'h0, 1'b0);
        run(16'h0880, 4'h0, 1'b0);
        run(16'h0801, 4'h0, 1'b0);
        run(16'h5E5F, 4'h3, 1'b1);
        run(16'h5E60, 4'h3, 1'b1);
        run(16'h5F60, 4'h5, 1'b1);
        run(16'h0C00, 4'h0, 1'b0);
        run(16'h5D10, 4'h2, 1'b0);
        run(16'h5C20, 4'h1, 1'b0);
        @(posedge clk);
        reset_pulse(2);
        run(16'h0803, 4'h0, 1'b0);
        repeat (80) begin
            r = $random(seed);
            // one word in eight is foreign and must be ignored
            run(r[5:3] == 3'h0 ? {8'h00, r[15:8]} : r[3] ? {8'h08, r[15:8]}
                : {6'h17, r[9:0]}, r[19:16], r[20]);
        end
        give_verdict;
    end
    initial begin
        #40000;
        fails++;
        give_verdict;
    end
endmodule
